// *** llsi_top.sv ***
// Purpose: Lock-loss monitor with hysteresis, clear delay, sticky flags and interrupt
// Assumes: All inputs synchronous to I_CLK_SYS; AXI4-Lite register access
// Notes: Clear delay counts clock cycles of I_CLK_SYS
//
// Our own choice: the AXI4-Lite slave port.

`timescale 1ns/1ps

module llsi_top (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   // Monitor inputs
   input wire logic [23:0] I_FREQ_ERR,
   input wire logic [3:0] I_LOS,
   // Status pins
   output logic O_LOCK_LOSS,
   output logic O_INTERRUPT_OUT_N_N,
   // AXI4-Lite write address and data
   input wire logic [11:0] I_AXI_AWADDR,
   input wire logic I_AXI_AWVALID,
   output logic O_AXI_AWREADY,
   input wire logic [31:0] I_AXI_WDATA,
   input wire logic [3:0] I_AXI_WSTRB,
   input wire logic I_AXI_WVALID,
   output logic O_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0] O_AXI_BRESP,
   output logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [11:0] I_AXI_ARADDR,
   input wire logic I_AXI_ARVALID,
   output logic O_AXI_ARREADY,
   output logic [31:0] O_AXI_RDATA,
   output logic [1:0] O_AXI_RRESP,
   output logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [23:0] thr_val(input logic [3:0] sel);
      case (sel)
         4'h0: thr_val = llsi_pkg::THR_0;
         4'h1: thr_val = llsi_pkg::THR_1;
         4'h2: thr_val = llsi_pkg::THR_2;
         4'h3: thr_val = llsi_pkg::THR_3;
         4'h4: thr_val = llsi_pkg::THR_4;
         4'h5: thr_val = llsi_pkg::THR_5;
         4'h6: thr_val = llsi_pkg::THR_6;
         4'h7: thr_val = llsi_pkg::THR_7;
         4'h8: thr_val = llsi_pkg::THR_8;
         4'h9: thr_val = llsi_pkg::THR_9;
         default: thr_val = llsi_pkg::THR_10;
      endcase
   endfunction

   function automatic logic is_mapped(input logic [9:0] idx);
      case (idx)
         llsi_pkg::IDX_LOS_LIVE, llsi_pkg::IDX_LOCK_LIVE, llsi_pkg::IDX_LOS_FLAG,
         llsi_pkg::IDX_LOCK_FLAG, llsi_pkg::IDX_LOCK_MASK, llsi_pkg::IDX_LOS_MASK,
         llsi_pkg::IDX_SET_THR, llsi_pkg::IDX_CLR_THR, llsi_pkg::IDX_TIMER_EN,
         llsi_pkg::IDX_DELAY0, llsi_pkg::IDX_DELAY1, llsi_pkg::IDX_DELAY2,
         llsi_pkg::IDX_DELAY3: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] rd_word(input logic [9:0] idx,
                                           input llsi_pkg::llsi_state_s s,
                                           input logic [3:0] los);
      rd_word = 32'h0000_0000;
      case (idx)
         llsi_pkg::IDX_LOS_LIVE: rd_word[3:0] = los;
         llsi_pkg::IDX_LOCK_LIVE: rd_word[llsi_pkg::LOCK_BIT] = s.live;
         llsi_pkg::IDX_LOS_FLAG: rd_word[3:0] = s.los_flag;
         llsi_pkg::IDX_LOCK_FLAG: rd_word[llsi_pkg::LOCK_BIT] = s.flag;
         llsi_pkg::IDX_LOCK_MASK: rd_word[llsi_pkg::LOCK_BIT] = s.lock_mask;
         llsi_pkg::IDX_LOS_MASK: rd_word[3:0] = s.los_mask;
         llsi_pkg::IDX_SET_THR: rd_word[7:4] = s.set_thr;
         llsi_pkg::IDX_CLR_THR: rd_word[7:4] = s.clr_thr;
         llsi_pkg::IDX_TIMER_EN: rd_word[llsi_pkg::TIMER_BIT] = s.timer_en;
         llsi_pkg::IDX_DELAY0: rd_word[7:0] = s.delay[7:0];
         llsi_pkg::IDX_DELAY1: rd_word[7:0] = s.delay[15:8];
         llsi_pkg::IDX_DELAY2: rd_word[7:0] = s.delay[23:16];
         llsi_pkg::IDX_DELAY3: rd_word[10:0] = s.delay[34:24];
         default: rd_word = 32'h0000_0000;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   llsi_pkg::llsi_state_s st_reg;
   llsi_pkg::llsi_state_s st_next;

   always_comb begin
      logic set_hit;
      logic clr_ok;
      logic do_wr;
      logic [9:0] aridx;
      set_hit = 1'b0;
      clr_ok = 1'b0;
      do_wr = 1'b0;
      aridx = I_AXI_ARADDR[11:2];
      st_next = st_reg;

      // ----------------------------------------------------------------
      // Lock monitor
      // ----------------------------------------------------------------
      set_hit = I_FREQ_ERR > thr_val(st_reg.set_thr);
      clr_ok = I_FREQ_ERR <= thr_val(st_reg.clr_thr);
      if (set_hit) begin
         st_next.live = 1'b1;
         st_next.cnt = '0;
      end else if (st_reg.live && clr_ok) begin
         if (!st_reg.timer_en) begin
            st_next.live = 1'b0;
            st_next.cnt = '0;
         end else if (st_reg.cnt >= st_reg.delay) begin
            st_next.live = 1'b0;
            st_next.cnt = '0;
         end else begin
            st_next.cnt = st_reg.cnt + 35'h0_0000_0001;
         end
      end else begin
         // Restart the delay if the error leaves the clear window
         st_next.cnt = '0;
      end

      // ----------------------------------------------------------------
      // AXI4-Lite write channel
      // ----------------------------------------------------------------
      if (st_reg.awready && I_AXI_AWVALID) begin
         st_next.aw_got = 1'b1;
         st_next.awidx = I_AXI_AWADDR[11:2];
      end
      if (st_reg.wready && I_AXI_WVALID) begin
         st_next.w_got = 1'b1;
         st_next.wdata = I_AXI_WDATA;
         st_next.wstrb = I_AXI_WSTRB;
      end
      do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
      if (do_wr) begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = is_mapped(st_reg.awidx) ? llsi_pkg::RESP_OKAY : llsi_pkg::RESP_DECERR;
         if (st_reg.wstrb[0]) begin
            case (st_reg.awidx)
               llsi_pkg::IDX_LOCK_FLAG: begin
                  // Clear refused while the alarm is live
                  if (!st_reg.wdata[llsi_pkg::LOCK_BIT] && !st_reg.live && !st_next.live) begin
                     st_next.flag = 1'b0;
                  end
               end
               llsi_pkg::IDX_LOS_FLAG: st_next.los_flag = st_reg.los_flag & (st_reg.wdata[3:0] | I_LOS);
               llsi_pkg::IDX_LOCK_MASK: st_next.lock_mask = st_reg.wdata[llsi_pkg::LOCK_BIT];
               llsi_pkg::IDX_LOS_MASK: st_next.los_mask = st_reg.wdata[3:0];
               llsi_pkg::IDX_SET_THR: st_next.set_thr = st_reg.wdata[7:4];
               llsi_pkg::IDX_CLR_THR: st_next.clr_thr = st_reg.wdata[7:4];
               llsi_pkg::IDX_TIMER_EN: st_next.timer_en = st_reg.wdata[llsi_pkg::TIMER_BIT];
               llsi_pkg::IDX_DELAY0: st_next.delay[7:0] = st_reg.wdata[7:0];
               llsi_pkg::IDX_DELAY1: st_next.delay[15:8] = st_reg.wdata[7:0];
               llsi_pkg::IDX_DELAY2: st_next.delay[23:16] = st_reg.wdata[7:0];
               llsi_pkg::IDX_DELAY3: st_next.delay[31:24] = st_reg.wdata[7:0];
               default: st_next.flag = st_next.flag;
            endcase
         end
         if (st_reg.wstrb[1] && st_reg.awidx == llsi_pkg::IDX_DELAY3) begin
            st_next.delay[34:32] = st_reg.wdata[10:8];
         end
      end
      if (st_reg.bvalid && I_AXI_BREADY) begin
         st_next.bvalid = 1'b0;
      end
      st_next.awready = !st_next.aw_got && !st_next.bvalid;
      st_next.wready = !st_next.w_got && !st_next.bvalid;

      // ----------------------------------------------------------------
      // Sticky flags; a set in the clearing cycle wins
      // ----------------------------------------------------------------
      st_next.flag = st_next.flag | st_next.live;
      st_next.los_flag = st_next.los_flag | I_LOS;

      // ----------------------------------------------------------------
      // AXI4-Lite read channel
      // ----------------------------------------------------------------
      if (st_reg.arready && I_AXI_ARVALID) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = rd_word(aridx, st_reg, I_LOS);
         st_next.rresp = is_mapped(aridx) ? llsi_pkg::RESP_OKAY : llsi_pkg::RESP_DECERR;
      end else if (st_reg.rvalid && I_AXI_RREADY) begin
         st_next.rvalid = 1'b0;
      end
      st_next.arready = !st_next.rvalid;

      // ----------------------------------------------------------------
      // Interrupt, active low
      // ----------------------------------------------------------------
      st_next.interrupt_out_n_n = !((st_next.flag && !st_next.lock_mask) ||
                         |(st_next.los_flag & ~st_next.los_mask));
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_reg <= llsi_pkg::ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_LOCK_LOSS = st_reg.live;
   assign O_INTERRUPT_OUT_N_N = st_reg.interrupt_out_n_n;
   assign O_AXI_AWREADY = st_reg.awready;
   assign O_AXI_WREADY = st_reg.wready;
   assign O_AXI_BVALID = st_reg.bvalid;
   assign O_AXI_BRESP = st_reg.bresp;
   assign O_AXI_ARREADY = st_reg.arready;
   assign O_AXI_RVALID = st_reg.rvalid;
   assign O_AXI_RDATA = st_reg.rdata;
   assign O_AXI_RRESP = st_reg.rresp;

endmodule // llsi_top

// *** llsi_pkg.sv ***
// Purpose: Constants and types for the lock-loss status and interrupt block
// Assumes: Register index = byte address / 4 on a 32-bit AXI4-Lite bus
// Notes: Frequency error and thresholds are in units of 0.1 ppm

package llsi_pkg;

   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_LOS_LIVE = 10'h00C;
   localparam logic [9:0] IDX_LOCK_LIVE = 10'h00E;
   localparam logic [9:0] IDX_LOS_FLAG = 10'h011;
   localparam logic [9:0] IDX_LOCK_FLAG = 10'h013;
   localparam logic [9:0] IDX_LOCK_MASK = 10'h017;
   localparam logic [9:0] IDX_LOS_MASK = 10'h018;
   localparam logic [9:0] IDX_SET_THR = 10'h09E;
   localparam logic [9:0] IDX_CLR_THR = 10'h0A0;
   localparam logic [9:0] IDX_TIMER_EN = 10'h0A2;
   localparam logic [9:0] IDX_DELAY0 = 10'h0A8;
   localparam logic [9:0] IDX_DELAY1 = 10'h0A9;
   localparam logic [9:0] IDX_DELAY2 = 10'h0AA;
   localparam logic [9:0] IDX_DELAY3 = 10'h0AB;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int LOCK_BIT = 1;
   localparam int TIMER_BIT = 1;
   localparam int THR_LSB = 4;
   localparam int NUM_LOS = 4;
   localparam int ERR_W = 24;
   localparam int DELAY_W = 35;
   localparam int ADDR_W = 12;

   // ----------------------------------------------------------------
   // Reset values and responses
   // ----------------------------------------------------------------
   localparam logic [3:0] SET_THR_RST = 4'h0;
   localparam logic [3:0] CLR_THR_RST = 4'h2;
   localparam logic [3:0] LOS_MASK_RST = 4'hF;
   localparam logic LOCK_MASK_RST = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------
   // Threshold table, 0.2 ppm up to 20000 ppm in 0.1 ppm units
   // ----------------------------------------------------------------
   localparam logic [23:0] THR_0 = 24'h00_0002;
   localparam logic [23:0] THR_1 = 24'h00_0006;
   localparam logic [23:0] THR_2 = 24'h00_0014;
   localparam logic [23:0] THR_3 = 24'h00_003C;
   localparam logic [23:0] THR_4 = 24'h00_00C8;
   localparam logic [23:0] THR_5 = 24'h00_0258;
   localparam logic [23:0] THR_6 = 24'h00_07D0;
   localparam logic [23:0] THR_7 = 24'h00_1770;
   localparam logic [23:0] THR_8 = 24'h00_4E20;
   localparam logic [23:0] THR_9 = 24'h00_EA60;
   localparam logic [23:0] THR_10 = 24'h03_0D40;

   // ----------------------------------------------------------------
   // State of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic live;
      logic flag;
      logic [3:0] los_flag;
      logic [3:0] set_thr;
      logic [3:0] clr_thr;
      logic timer_en;
      logic [34:0] delay;
      logic [34:0] cnt;
      logic lock_mask;
      logic [3:0] los_mask;
      logic interrupt_out_n_n;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_got;
      logic w_got;
      logic [9:0] awidx;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } llsi_state_s;

   localparam llsi_state_s ST_RESET = '{
      set_thr: SET_THR_RST,
      clr_thr: CLR_THR_RST,
      lock_mask: LOCK_MASK_RST,
      los_mask: LOS_MASK_RST,
      interrupt_out_n_n: 1'b1,
      default: '0
   };

endpackage

// *** llsi_sva.sv ***
// Purpose: Checker for the lock-loss status and interrupt block
// Assumes: Bound to the top module, sees its ports only
// Notes: Relations hold for any threshold or mask setting
`timescale 1ns/1ps
module llsi_sva (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   // Monitor and pins
   input wire logic [23:0] I_FREQ_ERR,
   input wire logic [3:0] I_LOS,
   input wire logic O_LOCK_LOSS,
   input wire logic O_INTERRUPT_OUT_N_N,
   // Bus
   input wire logic [11:0] I_AXI_ARADDR,
   input wire logic I_AXI_ARVALID,
   input wire logic O_AXI_ARREADY,
   input wire logic [31:0] O_AXI_RDATA,
   input wire logic O_AXI_RVALID,
   input wire logic I_AXI_RREADY,
   input wire logic [1:0] O_AXI_BRESP,
   input wire logic O_AXI_BVALID,
   input wire logic I_AXI_BREADY
);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   sequence s_rd_take;
      I_AXI_ARVALID && O_AXI_ARREADY;
   endsequence
   // Live bit unchanged across the taking edge, so the read must show it
   sequence s_live_read;
      (I_AXI_ARVALID && O_AXI_ARREADY && I_AXI_ARADDR == 12'h038) ##1 $stable(O_LOCK_LOSS);
   endsequence
   a_err_sets: assert property (I_FREQ_ERR > llsi_pkg::THR_10 |=> O_LOCK_LOSS)
      else $error("lock loss not held above top threshold");
   a_quiet_stays: assert property (!O_LOCK_LOSS && I_FREQ_ERR <= llsi_pkg::THR_0 |=> !O_LOCK_LOSS)
      else $error("lock loss raised below lowest threshold");
   a_interrupt_out_n_release: assert property ($rose(O_INTERRUPT_OUT_N_N) |-> $rose(O_AXI_BVALID))
      else $error("interrupt released without a register write");
   a_interrupt_out_n_cause: assert property ($fell(O_INTERRUPT_OUT_N_N) |->
      $rose(O_LOCK_LOSS) || (|I_LOS) || $past(|I_LOS) || $rose(O_AXI_BVALID))
      else $error("interrupt raised without a cause");
   a_read_answer: assert property (s_rd_take |=> O_AXI_RVALID)
      else $error("read answer late");
   a_rresp_hold: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
      O_AXI_RVALID && $stable(O_AXI_RDATA))
      else $error("read answer dropped");
   a_bresp_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=>
      O_AXI_BVALID && $stable(O_AXI_BRESP))
      else $error("write answer dropped");
   a_live_read: assert property (s_live_read |-> O_AXI_RDATA[1] == O_LOCK_LOSS)
      else $error("live bit differs from pin");
endmodule // llsi_sva
bind llsi_top llsi_sva llsi_sva_inst (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_FREQ_ERR(I_FREQ_ERR), .I_LOS(I_LOS),
   .O_LOCK_LOSS(O_LOCK_LOSS), .O_INTERRUPT_OUT_N_N(O_INTERRUPT_OUT_N_N), .I_AXI_ARADDR(I_AXI_ARADDR),
   .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA),
   .O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY), .O_AXI_BRESP(O_AXI_BRESP),
   .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY));

// *** llsi_host.sv ***
// Purpose: Host controller model on the register bus
// Assumes: One access at a time, all byte strobes set
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ps
module llsi_host (
   // Clock
   input wire logic i_clk,
   // Write channels
   output logic [11:0] o_awaddr,
   output logic o_awvalid,
   input wire logic i_awready,
   output logic [31:0] o_wdata,
   output logic [3:0] o_wstrb,
   output logic o_wvalid,
   input wire logic i_wready,
   input wire logic [1:0] i_bresp,
   input wire logic i_bvalid,
   output logic o_bready,
   // Read channels
   output logic [11:0] o_araddr,
   output logic o_arvalid,
   input wire logic i_arready,
   input wire logic [31:0] i_rdata,
   input wire logic [1:0] i_rresp,
   input wire logic i_rvalid,
   output logic o_rready
);
   initial begin
      {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
      {o_araddr, o_arvalid, o_rready} = '0;
      o_wstrb = 4'hF;
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_awaddr <= a;
      o_wdata <= d;
      {o_awvalid, o_wvalid, o_bready} <= 3'b111;
      fork
         begin
            do @(posedge i_clk); while (!i_awready);
            o_awvalid <= 1'b0;
            o_awaddr <= ~a;
         end
         begin
            do @(posedge i_clk); while (!i_wready);
            o_wvalid <= 1'b0;
            o_wdata <= ~d;
         end
      join
      while (!i_bvalid) @(posedge i_clk);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge i_clk);
      o_araddr <= a;
      {o_arvalid, o_rready} <= 2'b11;
      do @(posedge i_clk); while (!i_arready);
      o_arvalid <= 1'b0;
      o_araddr <= ~a;
      while (!i_rvalid) @(posedge i_clk);
      d = i_rdata;
      r = i_rresp;
      o_rready <= 1'b0;
   endtask
   // Service: clear only pending unmasked flags, leave the rest alone
   task automatic service();
      logic [31:0] f, m;
      logic [1:0] r;
      rd(12'h04C, f, r);
      rd(12'h05C, m, r);
      wr(12'h04C, ~(f & ~m), r);
      rd(12'h044, f, r);
      rd(12'h060, m, r);
      wr(12'h044, ~(f & ~m), r);
   endtask
endmodule // llsi_host

// *** lock_loss_status_interrupt_tb.sv ***
// Purpose: Self-checking bench for the lock-loss status and interrupt block
// Assumes: Clear timer off until the last scenario
// Notes: Thresholds come from the bench's own thr function
`timescale 1ns/1ps
module lock_loss_status_interrupt_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [23:0] err = 24'h00_0000;
   logic [3:0] los = 4'h0;
   logic lock_loss, interrupt_out_n_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int mismatches = 0;
   int checks_done = 0;
   localparam logic [11:0] DA [6] = '{12'h278, 12'h280, 12'h288, 12'h05C, 12'h060, 12'h2A0};
   localparam logic [31:0] DM [6] = '{32'h0000_00F0, 32'h0000_00F0, 32'h0000_0002,
      32'h0000_0002, 32'h0000_000F, 32'h0000_00FF};
   localparam logic [31:0] DE [6] = '{32'h0000_0000, 32'h0000_0020, 32'h0000_0000,
      32'h0000_0000, 32'h0000_000F, 32'h0000_0000};
   always #2 clk = ~clk;
   llsi_top llsi_top_inst (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_FREQ_ERR(err), .I_LOS(los),
      .O_LOCK_LOSS(lock_loss), .O_INTERRUPT_OUT_N_N(interrupt_out_n_n),
      .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
      .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
      .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
      .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
      .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready));
   llsi_host llsi_host_inst (
      .i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
      .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
      .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
      .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
      .i_rvalid(rvalid), .o_rready(rready));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Error lands at one edge, the monitor answers at the next
   task automatic drive(input logic [23:0] v);
      @(posedge clk);
      err <= v;
      @(posedge clk);
      #1;
   endtask
   function automatic logic [23:0] thr(input int sel);
      thr = (sel % 2) ? 24'h00_0006 : 24'h00_0002;
      repeat (sel / 2) thr = thr * 10;
   endfunction
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int n, dl;
      d = $urandom(57);
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk(lock_loss, 0);
      chk(interrupt_out_n_n, 1);
      for (int i = 0; i < 6; i++) begin
         llsi_host_inst.rd(DA[i], d, r);
         chk(d & DM[i], DE[i]);
      end
      llsi_host_inst.rd(12'h004, d, r);
      chk(r, llsi_pkg::RESP_DECERR);
      llsi_host_inst.wr(12'h004, 32'hFFFF_FFFF, r);
      chk(r, llsi_pkg::RESP_DECERR);
      llsi_host_inst.wr(12'h2AC, 32'hFFFF_FFFF, r);
      chk(r, llsi_pkg::RESP_OKAY);
      llsi_host_inst.rd(12'h2AC, d, r);
      chk(d, 32'h0000_07FF);
      llsi_host_inst.wr(12'h2AC, 32'h0000_0000, r);
      for (int s = 0; s < 11; s++) begin
         // Clear level kept at or below set level, else the set compare holds the alarm
         n = $urandom_range(s, 0);
         llsi_host_inst.wr(12'h278, s << 4, r);
         llsi_host_inst.wr(12'h280, n << 4, r);
         drive(thr(s));
         chk(lock_loss, 0);
         drive(thr(s) + 24'h00_0001);
         chk(lock_loss, 1);
         chk(interrupt_out_n_n, 0);
         drive(thr(n) + 24'h00_0001);
         chk(lock_loss, 1);
         drive(thr(n));
         chk(lock_loss, 0);
         drive(24'h00_0000);
      end
      drive(24'hFF_FFFF);
      llsi_host_inst.rd(12'h038, d, r);
      chk(d[1], 1);
      llsi_host_inst.wr(12'h04C, 32'h0000_0000, r);
      llsi_host_inst.rd(12'h04C, d, r);
      chk(d[1], 1);
      chk(interrupt_out_n_n, 0);
      drive(24'h00_0000);
      chk(interrupt_out_n_n, 0);
      llsi_host_inst.rd(12'h038, d, r);
      chk(d[1], 0);
      llsi_host_inst.service();
      chk(interrupt_out_n_n, 1);
      llsi_host_inst.wr(12'h05C, 32'h0000_0002, r);
      drive(24'hFF_FFFF);
      chk(interrupt_out_n_n, 1);
      drive(24'h00_0000);
      llsi_host_inst.wr(12'h060, 32'h0000_000E, r);
      @(posedge clk);
      los <= 4'h1;
      n = 0;
      while (interrupt_out_n_n !== 1'b0 && n < 8) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk(interrupt_out_n_n, 0);
      @(posedge clk);
      los <= 4'h0;
      llsi_host_inst.service();
      chk(interrupt_out_n_n, 1);
      dl = $urandom_range(12, 3);
      llsi_host_inst.wr(12'h2A0, dl, r);
      llsi_host_inst.wr(12'h288, 32'h0000_0002, r);
      drive(24'hFF_FFFF);
      drive(24'h00_0000);
      n = 0;
      while (lock_loss !== 1'b0 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      // Delay plus one qualifying edges, the first of them inside drive
      chk(n, dl);
      conclude();
   end
endmodule // lock_loss_status_interrupt_tb
